//--- pkg/tssw_pkg.sv
package tssw_pkg;

  // ==========================================================
  // counter and timing
  // ==========================================================
  localparam int unsigned CNT_W = 16;
  localparam logic [CNT_W-1:0] PERIOD_RST = 16'hFFFF;
  localparam logic [CNT_W-1:0] FIRST_PT_RST = 16'h8000;
  localparam logic [CNT_W-1:0] SECOND_PT_RST = 16'hFFFF;

  // secure stage count of low-frequency ticks, reset value
  localparam logic [CNT_W-1:0] SEC_PERIOD_RST = 16'h0100;
  localparam logic [CNT_W-1:0] SEC_GRACE_RST = 16'h0040;

  // least event-out hold in low-frequency clock cycles
  localparam int unsigned EVT_HOLD_RTC_CYC = 1;

  // ==========================================================
  // carriers
  // ==========================================================
  typedef struct packed {
    logic enable;
    logic irq1_en;
    logic irq2_en;
    logic [CNT_W-1:0] first_pt;
    logic [CNT_W-1:0] second_pt;
  } tssw_cfg_t;

  typedef struct packed {
    logic enable;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] grace;
  } tssw_sec_cfg_t;

  typedef enum logic [2:0] {
    SW_IDLE = 3'h1,
    SW_RUN = 3'h2,
    SW_ALARM = 3'h4
  } tssw_sec_state_t;

endpackage

//--- rtl/tssw_top.sv
`timescale 1ns/1ps

// How it works
// - two comparison points checked every period
// - each point may raise core interrupt
// - second point drives watchdog event line
// - secure watchdog times out unless serviced
// - time-out raises secure-world forcing interrupt
// - still unserviced: flag security check unit
// - non-secure writes to secure watchdog ignored
// - event out held one rtc cycle minimum
module tssw_top #(
  parameter int unsigned CNT_W = tssw_pkg::CNT_W
) (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  // low-frequency rtc clock, sampled as a plain input
  input wire logic LOW_FREQ_RTC_CLOCK_I,
  // general watchdog control
  input wire tssw_pkg::tssw_cfg_t CFG_I,
  input wire logic CFG_WE_I,
  input wire logic SERVICE_I,
  // secure watchdog control
  input wire tssw_pkg::tssw_sec_cfg_t SEC_CFG_I,
  input wire logic SEC_CFG_WE_I,
  input wire logic SEC_SERVICE_I,
  input wire logic SECURE_ACCESS_I,
  // outputs
  output logic IRQ_O,
  output logic WATCHDOG_EVENT_OUT_O,
  output logic SECURE_IRQ_O,
  output logic SECURITY_VIOLATION_O,
  output logic [CNT_W-1:0] COUNT_O,
  output logic SEC_ACTIVE_O
);

  // ==========================================================
  // reset release
  // ==========================================================
  logic rst_s1_q;
  logic rst_n;

  // async assert, release through two flops
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // ==========================================================
  // low-frequency tick
  // ==========================================================
  logic rtc_d1_q;
  logic rtc_d2_q;
  wire rtc_tick = rtc_d1_q & ~rtc_d2_q; // rising edge of rtc clock

  // input is synchronous, so edge detect needs no synchroniser
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      rtc_d1_q <= 1'b0;
      rtc_d2_q <= 1'b0;
    end else begin
      rtc_d1_q <= LOW_FREQ_RTC_CLOCK_I;
      rtc_d2_q <= rtc_d1_q;
    end
  end

  // ==========================================================
  // general watchdog
  // ==========================================================
  tssw_pkg::tssw_cfg_t cfg_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic irq1_q;
  logic irq2_q;
  logic evt_q;
  logic [1:0] evt_hold_q;

  wire hit_first = cfg_q.enable & rtc_tick & (cnt_q == cfg_q.first_pt);
  wire hit_second = cfg_q.enable & rtc_tick & (cnt_q == cfg_q.second_pt);
  wire cnt_wrap = cnt_q == cfg_q.second_pt;

  // counting restarts after the second point or on service
  always_comb begin
    cnt_d = cnt_q;
    if (SERVICE_I || !cfg_q.enable) begin
      cnt_d = '0;
    end else if (rtc_tick) begin
      cnt_d = cnt_wrap ? '0 : cnt_q + 1'b1;
    end
  end

  // config and counter registers
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= '{enable: 1'b0, irq1_en: 1'b0, irq2_en: 1'b0,
                 first_pt: tssw_pkg::FIRST_PT_RST, second_pt: tssw_pkg::SECOND_PT_RST};
      cnt_q <= '0;
    end else begin
      if (CFG_WE_I) begin
        cfg_q <= CFG_I;
      end
      cnt_q <= cnt_d;
    end
  end

  // interrupt flags: a hit wins over a service in the same cycle
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      irq1_q <= 1'b0;
      irq2_q <= 1'b0;
    end else begin
      irq1_q <= (hit_first & cfg_q.irq1_en) | (irq1_q & ~SERVICE_I);
      irq2_q <= (hit_second & cfg_q.irq2_en) | (irq2_q & ~SERVICE_I);
    end
  end

  // event line; hold counts whole rtc periods so it never drops early
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      evt_q <= 1'b0;
      evt_hold_q <= 2'h0;
    end else if (hit_second) begin
      evt_q <= 1'b1;
      evt_hold_q <= 2'(tssw_pkg::EVT_HOLD_RTC_CYC + 1);
    end else if (evt_q && rtc_tick) begin
      // two ticks give at least one full rtc period of assertion
      evt_hold_q <= evt_hold_q - 2'h1;
      if (evt_hold_q == 2'h1) begin
        evt_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // secure watchdog
  // ==========================================================
  tssw_pkg::tssw_sec_cfg_t sec_cfg_q;
  tssw_pkg::tssw_sec_state_t sec_state_q;
  tssw_pkg::tssw_sec_state_t sec_state_d;
  logic [CNT_W-1:0] sec_cnt_q;
  logic [CNT_W-1:0] sec_cnt_d;
  logic sec_irq_q;
  logic sec_viol_q;

  // only secure software may touch config, running or not
  wire sec_cfg_ok = SEC_CFG_WE_I & SECURE_ACCESS_I;
  wire sec_srv = SEC_SERVICE_I & SECURE_ACCESS_I;
  wire sec_expire = rtc_tick & (sec_cnt_q == '0);

  // state and down-counter next values
  always_comb begin
    sec_state_d = sec_state_q;
    sec_cnt_d = sec_cnt_q;
    unique case (sec_state_q)
      tssw_pkg::SW_IDLE: begin
        if (sec_cfg_ok && SEC_CFG_I.enable) begin
          sec_state_d = tssw_pkg::SW_RUN;
          sec_cnt_d = SEC_CFG_I.period;
        end
      end
      tssw_pkg::SW_RUN: begin
        if (sec_srv) begin
          sec_cnt_d = sec_cfg_q.period;
        end else if (sec_expire) begin
          sec_state_d = tssw_pkg::SW_ALARM;
          sec_cnt_d = sec_cfg_q.grace;
        end else if (rtc_tick) begin
          sec_cnt_d = sec_cnt_q - 1'b1;
        end
      end
      tssw_pkg::SW_ALARM: begin
        if (sec_srv) begin
          sec_state_d = tssw_pkg::SW_RUN;
          sec_cnt_d = sec_cfg_q.period;
        end else if (rtc_tick && sec_cnt_q != '0) begin
          sec_cnt_d = sec_cnt_q - 1'b1;
        end
      end
      default: begin
        sec_state_d = tssw_pkg::SW_IDLE;
      end
    endcase
  end

  // secure registers; enable is sticky, so it cannot be turned off
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      sec_cfg_q <= '{enable: 1'b0, period: tssw_pkg::SEC_PERIOD_RST, grace: tssw_pkg::SEC_GRACE_RST};
      sec_state_q <= tssw_pkg::SW_IDLE;
      sec_cnt_q <= '0;
    end else begin
      if (sec_cfg_ok) begin
        sec_cfg_q.period <= SEC_CFG_I.period;
        sec_cfg_q.grace <= SEC_CFG_I.grace;
        sec_cfg_q.enable <= sec_cfg_q.enable | SEC_CFG_I.enable;
      end
      sec_state_q <= sec_state_d;
      sec_cnt_q <= sec_cnt_d;
    end
  end

  // escalation outputs; violation is never undone by service
  always_ff @(posedge SYS_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      sec_irq_q <= 1'b0;
      sec_viol_q <= 1'b0;
    end else begin
      if (sec_state_q == tssw_pkg::SW_RUN && sec_expire && !sec_srv) begin
        sec_irq_q <= 1'b1;
      end else if (sec_srv) begin
        sec_irq_q <= 1'b0;
      end
      if (sec_state_q == tssw_pkg::SW_ALARM && sec_expire && !sec_srv) begin
        sec_viol_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign IRQ_O = irq1_q | irq2_q;
  assign WATCHDOG_EVENT_OUT_O = evt_q;
  assign SECURE_IRQ_O = sec_irq_q;
  assign SECURITY_VIOLATION_O = sec_viol_q;
  assign COUNT_O = cnt_q;
  assign SEC_ACTIVE_O = sec_state_q != tssw_pkg::SW_IDLE;

endmodule

//--- sim/testbench.sv
`timescale 1ns/1ps
// ==========================================================
// testbench
// ==========================================================
module testbench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] rtc_div = 3'h0;
  logic [3:0] stb = 4'h0;
  logic sec_acc = 1'b0;
  tssw_pkg::tssw_cfg_t cfg = '{1'b1, 1'b1, 1'b1, 16'h0002, 16'h0004};
  tssw_pkg::tssw_sec_cfg_t sec_cfg = '{1'b1, 16'h0003, 16'h0002};
  logic irq, evt, sirq, viol, sact, smode, vseen;
  logic [15:0] cnt;
  logic [7:0] icnt;
  int n_errors = 0;
  int comparisons = 0;
  wire [3:0] obs = {viol, sirq, evt, irq};
  // rtc period of eight system cycles keeps the run short
  always #2 clk = ~clk;
  always @(posedge clk) rtc_div <= rtc_div + 3'h1;
  tssw_top dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .LOW_FREQ_RTC_CLOCK_I(rtc_div[2]), .CFG_I(cfg),
    .CFG_WE_I(stb[0]), .SERVICE_I(stb[1]), .SEC_CFG_I(sec_cfg), .SEC_CFG_WE_I(stb[2]),
    .SEC_SERVICE_I(stb[3]), .SECURE_ACCESS_I(sec_acc), .IRQ_O(irq), .WATCHDOG_EVENT_OUT_O(evt),
    .SECURE_IRQ_O(sirq), .SECURITY_VIOLATION_O(viol), .COUNT_O(cnt), .SEC_ACTIVE_O(sact));
  tssw_core_model u_core (.clk_i(clk), .rst_n_i(rst_n), .irq_i(irq), .sec_irq_i(sirq), .viol_i(viol),
    .secure_mode_o(smode), .viol_seen_o(vseen), .irq_cnt_o(icnt));
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one width for every compare, so no value is cut on its way in
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // strobes drop one edge after rising, so back to back pulses never collide
  task automatic pulse(input int b, input logic acc);
    @(posedge clk);
    sec_acc <= acc;
    stb[b] <= 1'b1;
    @(posedge clk);
    stb <= 4'h0;
    #1;
  endtask
  task automatic wait_bit(input int b);
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk);
      #1;
      if (obs[b] === 1'b1) return;
    end
    n_errors++;
    final_report();
  endtask
  task automatic t_general();
    pulse(0, 1'b0);
    wait_bit(0);
    chk(32'(evt), 32'h0);
    wait_bit(1);
    chk(32'(irq), 32'h1);
    chk(32'(icnt), 32'h1);
    // let one tick pass so the service has a nonzero count to clear
    repeat (8) @(posedge clk);
    #1;
    chk(32'(cnt), 32'h1);
    pulse(1, 1'b0);
    chk(32'(irq), 32'h0);
    chk(32'(cnt), 32'h0);
    cfg.enable <= 1'b0;
    pulse(0, 1'b0);
    repeat (40) @(posedge clk);
    #1;
    chk(32'(cnt), 32'h0);
    chk(32'(obs[1:0]), 32'h0);
    // both stage interrupts masked: the event line must still fire alone
    cfg <= '{1'b1, 1'b0, 1'b0, 16'h0002, 16'h0004};
    pulse(0, 1'b0);
    wait_bit(1);
    chk(32'({icnt, irq}), 32'h2);
    $display("general watchdog test done");
  endtask
  task automatic t_secure();
    pulse(2, 1'b0);
    chk(32'(sact), 32'h0);
    pulse(2, 1'b1);
    chk(32'(sact), 32'h1);
    repeat (6) begin
      repeat (16) @(posedge clk);
      pulse(3, 1'b1);
    end
    chk(32'(sirq), 32'h0);
    sec_cfg.enable <= 1'b0;
    pulse(2, 1'b0);
    chk(32'(sact), 32'h1);
    wait_bit(2);
    chk(32'(viol), 32'h0);
    pulse(3, 1'b0);
    chk(32'(sirq), 32'h1);
    // the core model takes the line one edge late, so look only after the pulse
    chk(32'(smode), 32'h1);
    pulse(3, 1'b1);
    chk(32'(sirq), 32'h0);
    wait_bit(2);
    wait_bit(3);
    chk(32'(sirq), 32'h1);
    pulse(3, 1'b1);
    chk(32'({vseen, viol, sirq}), 32'h6);
    $display("secure watchdog test done");
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(32'({obs, sact, cnt}), 32'h0);
    t_general();
    t_secure();
    final_report();
  end
endmodule

//--- sim/tssw_chk.sv
`timescale 1ns/1ps
// ==========================================================
// port checker
// ==========================================================
module tssw_chk #(
  parameter int unsigned CNT_W = 16
) (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  // requests
  input wire logic SERVICE_I,
  input wire logic SEC_SERVICE_I,
  input wire logic SEC_CFG_WE_I,
  input wire logic SECURE_ACCESS_I,
  // answers
  input wire logic IRQ_O,
  input wire logic WATCHDOG_EVENT_OUT_O,
  input wire logic SECURE_IRQ_O,
  input wire logic SECURITY_VIOLATION_O,
  input wire logic [CNT_W-1:0] COUNT_O,
  input wire logic SEC_ACTIVE_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  // eight cycles is one rtc period of the bench, so a short event shows here
  property p_evt_hold; $rose(WATCHDOG_EVENT_OUT_O) |-> WATCHDOG_EVENT_OUT_O [*8]; endproperty
  a_evt_hold: assert property (p_evt_hold) else $error("event line dropped early");
  property p_evt_wrap; $rose(WATCHDOG_EVENT_OUT_O) |-> COUNT_O == 16'h0000; endproperty
  a_evt_wrap: assert property (p_evt_wrap) else $error("no wrap with event");
  property p_step; $changed(COUNT_O) |-> COUNT_O == $past(COUNT_O) + 16'h0001 || COUNT_O == 16'h0000; endproperty
  a_step: assert property (p_step) else $error("counter jumped");
  property p_svc; SERVICE_I |=> COUNT_O == 16'h0000; endproperty
  a_svc: assert property (p_svc) else $error("service did not reload");
  property p_irq_hold; IRQ_O && !SERVICE_I |=> IRQ_O; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("core irq dropped");
  property p_sirq_hold; SECURE_IRQ_O && !(SEC_SERVICE_I && SECURE_ACCESS_I) |=> SECURE_IRQ_O; endproperty
  a_sirq_hold: assert property (p_sirq_hold) else $error("secure irq dropped");
  property p_viol; $rose(SECURITY_VIOLATION_O) |-> $past(SECURE_IRQ_O); endproperty
  a_viol: assert property (p_viol) else $error("violation without secure irq");
  property p_viol_stay; SECURITY_VIOLATION_O |=> SECURITY_VIOLATION_O; endproperty
  a_viol_stay: assert property (p_viol_stay) else $error("violation cleared");
  property p_lock; SEC_ACTIVE_O |=> SEC_ACTIVE_O; endproperty
  a_lock: assert property (p_lock) else $error("secure watchdog stopped");
  property p_nonsec; !SEC_ACTIVE_O && !(SEC_CFG_WE_I && SECURE_ACCESS_I) |=> !SEC_ACTIVE_O; endproperty
  a_nonsec: assert property (p_nonsec) else $error("started without secure write");
endmodule
bind tssw_top tssw_chk #(.CNT_W(CNT_W)) u_chk (.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I),
  .SERVICE_I(SERVICE_I), .SEC_SERVICE_I(SEC_SERVICE_I), .SEC_CFG_WE_I(SEC_CFG_WE_I),
  .SECURE_ACCESS_I(SECURE_ACCESS_I), .IRQ_O(IRQ_O), .WATCHDOG_EVENT_OUT_O(WATCHDOG_EVENT_OUT_O),
  .SECURE_IRQ_O(SECURE_IRQ_O), .SECURITY_VIOLATION_O(SECURITY_VIOLATION_O), .COUNT_O(COUNT_O),
  .SEC_ACTIVE_O(SEC_ACTIVE_O));

//--- sim/tssw_core_model.sv
`timescale 1ns/1ps
// ==========================================================
// core interrupt logic and security check unit
// ==========================================================
module tssw_core_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // lines from the watchdog
  input wire logic irq_i,
  input wire logic sec_irq_i,
  input wire logic viol_i,
  // observed state
  output logic secure_mode_o,
  output logic viol_seen_o,
  output logic [7:0] irq_cnt_o
);
  logic irq_q;
  // secure mode is sticky: normal software cannot leave it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_q <= 1'b0;
      secure_mode_o <= 1'b0;
      viol_seen_o <= 1'b0;
      irq_cnt_o <= 8'h00;
    end else begin
      irq_q <= irq_i;
      if (irq_i && !irq_q) irq_cnt_o <= irq_cnt_o + 8'h01;
      if (sec_irq_i) secure_mode_o <= 1'b1;
      if (viol_i) viol_seen_o <= 1'b1;
    end
  end
endmodule
